// >>> common/hfm_params.svh
// Purpose: constants for the hypervisor fence and machine status control block
// Assumes: one hart clock, 32-bit machine register width
// Notes:  fence decode, trap-time status update, return restore, privilege modification
`ifndef HFM_PARAMS_SVH
`define HFM_PARAMS_SVH
`define HFM_XLEN        32
`define HFM_TAG_MAX     9
`define HFM_TAG_LEN     6
`define HFM_VIRTUAL_MACHINE_IDENTIFIER_MAX    7
`define HFM_VIRTUAL_MACHINE_IDENTIFIER_LEN    4
`define HFM_GPA_SHIFT   2
`define HFM_PRIV_M      2'h3
`define HFM_PRIV_S      2'h1
`define HFM_PRIV_U      2'h0
`define HFM_BIT_PV      7
`define HFM_BIT_GVA     6
`define HFM_BIT_MBE     5
`define HFM_BIT_SBE     4
`define HFM_RESET_PV    1'h0
`define HFM_RESET_GVA   1'h0
`define HFM_ADDR_SH     12'h000
`define HFM_ADDR_CTL    12'h001
`define HFM_SH_MASK     32'h000000F0
`endif

// >>> common/hfm_pkg.sv
// Purpose: types for the hypervisor fence and machine status control block
// Assumes: hfm_params.svh gives the widths
// Notes:  carriers group fence requests and answers
`include "hfm_params.svh"
package hfm_pkg;
   // Fence kinds decoded by the pipeline
   typedef enum logic [1:0] {FK_NONE, FK_CUR, FK_GVV, FK_GPV} hfm_fence_kind_t;
   // Exceptions selected for a fence
   typedef enum logic [1:0] {EX_NONE, EX_ILLEGAL, EX_VIRTUAL} hfm_exc_t;
   // Fence request from the pipeline
   typedef struct packed {
      logic                      valid;
      hfm_fence_kind_t           kind;
      logic                      rs1Nz;
      logic                      rs2Nz;
      logic [`HFM_XLEN-1:0]      rs1Val;
      logic [`HFM_XLEN-1:0]      rs2Val;
   } hfm_fence_req_t;
   // Flush command to the translation caches
   typedef struct packed {
      logic                      valid;
      logic                      curTable;   // Host table when low virt, guest when virt
      logic                      guestTable; // Guest supervisor stage
      logic                      gStage;     // Stage-two entries
      logic                      global;     // Ignore address, tag and identifier
      logic                      useAddr;
      logic                      useTag;
      logic [`HFM_XLEN-1:0]      addr;
      logic [`HFM_TAG_LEN-1:0]   tag;
      logic [`HFM_VIRTUAL_MACHINE_IDENTIFIER_LEN-1:0]  virtual_machine_identifier;
      logic                      orderStores; // Drain visible stores first
   } hfm_flush_t;
   // Effective access mode for explicit memory accesses
   typedef struct packed {
      logic       virt;
      logic [1:0] priv;
      logic       bigEnd;
   } hfm_access_t;
endpackage

// >>> src/hfm_ctl.sv
// Purpose: fence legality and flush scope, status trap and return updates
// Assumes: pipeline gives one-cycle pulses; trap and return never in the same cycle
// Notes:  fence results and flush are registered, one cycle after the request
`timescale 1ns/1ps
`include "hfm_params.svh"
module hfm_ctl #(
   parameter bit SIMPLE = 1'b0          // Global fences, ignoring operands
) (
   input  wire logic                    clk,
   input  wire logic                    nrst,
   input  wire logic                    ce,
   input  wire logic [1:0]              priv,        // Current nominal privilege
   input  wire logic                    virt,        // Current virtualization mode
   input  wire logic [1:0]              priorPriv,   // Prior privilege field
   input  wire logic                    modPriv,     // Modified privilege bit
   input  wire logic                    trapTm,      // Trap translation management
   input  wire logic                    trapSr,      // Trap supervisor return
   input  wire logic                    trapWait,    // Trap wait bit
   input  wire logic [`HFM_VIRTUAL_MACHINE_IDENTIFIER_LEN-1:0] curVmid,    // Stage-two table identifier
   input  wire logic                    bigEndS,     // Unused; sub-machine byte order comes from the status bits
   input  wire hfm_pkg::hfm_fence_req_t fenceReq,
   input  wire logic                    trapTaken,   // Trap into machine mode
   input  wire logic                    trapGva,     // Trap value is guest virtual
   input  wire logic                    mretDo,      // Machine trap return
   input  wire logic                    gTableAcc,   // Access to stage-two table register
   input  wire logic                    srIssue,     // Supervisor trap return issued
   input  wire logic                    waitIssue,   // Wait-for-interrupt issued
   input  wire logic [11:0]             regAddr,
   input  wire logic [31:0]             regWdata,
   input  wire logic                    regWr,
   input  wire logic                    regRd,
   output logic [31:0]                  regRdata,
   output hfm_pkg::hfm_exc_t            fenceExc,    // Registered fence outcome
   output hfm_pkg::hfm_flush_t          flush,       // Registered flush command
   output logic                         gTableBlock, // Stage-two table access traps
   output logic                         srTrap,
   output logic                         waitTrap,
   output logic                         newVirt,     // Virtualization after return
   output logic                         newVirtVld,
   output hfm_pkg::hfm_access_t         access
);
   import hfm_pkg::*;

   // Overview
   //
   // Fence path
   // One decoded fence arrives per pulse.
   // Legality is decided in the same cycle.
   // The outcome is registered, so exception code
   // and flush command appear together, one cycle
   // after the request was taken.
   // Check order: virtualized, then user mode,
   // then the stage-two trap bit.
   // A virtualized user fence thus gets the
   // virtual fault, so the hypervisor can emulate it.
   // The current fence is never refused here;
   // its own trap rules live outside this block.
   // A refused fence sends no flush, so a trapping
   // guest cannot drop the host's translations.
   //
   // Flush scope
   // Every legal fence asks for store draining
   // before later table walks.
   // That is stronger than the guest virtual fence
   // needs, but keeps the cache side simple at the
   // cost of a few stall cycles.
   // The guest virtual fence uses the identifier in
   // force now; a later change does not move it.
   // The stage-two address arrives shifted right and
   // is shifted back here; bits above the register
   // width are lost. Caches that track such addresses
   // must flush the whole identifier instead.
   // Operand bits above the implemented widths are
   // dropped by part-selects.
   //
   // Status bits
   // Prior virtualization and guest address flag are
   // written by traps and by software.
   // A trap beats a software write in the same cycle;
   // losing trap state would break the return.
   // Byte-order bits are software only.
   // The simple-fence control is a local extension
   // that forces every fence to global scope.
   //
   // Return and access mode
   // The return restore is registered and flagged
   // for one cycle; the pipeline switches on the flag.
   // The access mode is combinational, so the
   // load-store unit sees it in the cycle the
   // modified-privilege bit changes.
   //
   // Clock enable
   // Low freezes every register, but not reset.
   // The byte-order input is not used: byte order
   // comes from the status register bits.
   //

   logic          pv_r;        // Prior virtualization bit
   logic          gva_r;       // Guest address flag
   logic          mbe_r;       // Machine big endian
   logic          sbe_r;       // Supervisor byte order
   logic          simple_r;    // Software-selectable global fences
   hfm_exc_t      exc_nxt;
   hfm_flush_t    flush_nxt;
   hfm_exc_t      exc_r;
   hfm_flush_t    flush_r;
   logic          nv_r;
   logic          nvv_r;
   logic [31:0]   rd_r;
   logic          hsMode;      // Hypervisor-supervisor mode

   assign hsMode = (priv == `HFM_PRIV_S) && !virt;

   // Legality and flush scope of the decoded fence
   always_comb begin
      exc_nxt   = EX_NONE;
      flush_nxt = '0;
      // Idle cycles leave both outputs at rest
      if (fenceReq.valid && fenceReq.kind != FK_NONE) begin
         if (fenceReq.kind != FK_CUR && virt) begin
            exc_nxt = EX_VIRTUAL;
         end else if (fenceReq.kind != FK_CUR && priv == `HFM_PRIV_U) begin
            exc_nxt = EX_ILLEGAL;
         end else if (fenceReq.kind == FK_GPV && hsMode && trapTm) begin
            exc_nxt = EX_ILLEGAL;
         end
         // Guest virtual fence left untouched by either trap bit
         if (exc_nxt == EX_NONE) begin
            flush_nxt.valid       = 1'b1;
            flush_nxt.orderStores = 1'b1;
            flush_nxt.virtual_machine_identifier        = curVmid;
            flush_nxt.global      = SIMPLE || simple_r;
            // Scope depends on which structures the kind owns
            case (fenceReq.kind)
               FK_CUR: begin
                  flush_nxt.curTable   = 1'b1;
                  flush_nxt.guestTable = virt;
                  flush_nxt.useAddr    = fenceReq.rs1Nz;
                  flush_nxt.useTag     = fenceReq.rs2Nz;
                  flush_nxt.addr       = fenceReq.rs1Val;
                  flush_nxt.tag        = fenceReq.rs2Val[`HFM_TAG_LEN-1:0];
               end
               FK_GVV: begin
                  // Scoped to the identifier in force now
                  flush_nxt.guestTable = 1'b1;
                  flush_nxt.useAddr    = fenceReq.rs1Nz;
                  flush_nxt.useTag     = fenceReq.rs2Nz;
                  flush_nxt.addr       = fenceReq.rs1Val;
                  // Upper tag bits dropped: reserved or unimplemented
                  flush_nxt.tag        = fenceReq.rs2Val[`HFM_TAG_LEN-1:0];
               end
               FK_GPV: begin
                  flush_nxt.gStage  = 1'b1;
                  flush_nxt.useAddr = fenceReq.rs1Nz;
                  flush_nxt.useTag  = fenceReq.rs2Nz;
                  // Operand holds address shifted right; restore byte address
                  flush_nxt.addr    = fenceReq.rs1Val << `HFM_GPA_SHIFT;
                  // Identifier from operand, upper bits ignored
                  if (fenceReq.rs2Nz) begin
                     flush_nxt.virtual_machine_identifier = fenceReq.rs2Val[`HFM_VIRTUAL_MACHINE_IDENTIFIER_LEN-1:0];
                  end
                  // Without an identifier operand, all machines
                  flush_nxt.global = SIMPLE || simple_r || !fenceReq.rs2Nz;
               end
               // Unreachable, kept safe: no flush
               default: begin
                  flush_nxt.valid = 1'b0;
               end
            endcase
         end
      end
   end

   // Fence outcome register
   // Registering keeps the cache-side timing
   // independent of the decode depth
   always_ff @(posedge clk) begin
      if (!nrst) begin
         exc_r   <= EX_NONE;
         flush_r <= '0;
      end else if (ce) begin
         exc_r   <= exc_nxt;
         flush_r <= flush_nxt;
      end
   end

   // Prior virtualization bit: trap capture, software write
   // Trap first: the handler needs the mode
   // that was in force when it was entered
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pv_r <= `HFM_RESET_PV;
      end else if (ce) begin
         if (trapTaken) begin
            pv_r <= virt;
         end else if (regWr && regAddr == `HFM_ADDR_SH) begin
            pv_r <= regWdata[`HFM_BIT_PV];
         end
      end
   end

   // Guest address flag: trap wins over a software write
   // Every trap writes it, so a stale one
   // never survives into the next handler
   always_ff @(posedge clk) begin
      if (!nrst) begin
         gva_r <= `HFM_RESET_GVA;
      end else if (ce) begin
         if (trapTaken) begin
            gva_r <= trapGva;
         end else if (regWr && regAddr == `HFM_ADDR_SH) begin
            gva_r <= regWdata[`HFM_BIT_GVA];
         end
      end
   end

   // Byte order bits and the simple-fence control
   // Software owned; no hardware event
   // touches these bits
   always_ff @(posedge clk) begin
      if (!nrst) begin
         mbe_r    <= 1'b0;
         sbe_r    <= 1'b0;
         simple_r <= 1'b0;
      end else if (ce && regWr) begin
         if (regAddr == `HFM_ADDR_SH) begin
            mbe_r <= regWdata[`HFM_BIT_MBE];
            sbe_r <= regWdata[`HFM_BIT_SBE];
         end else if (regAddr == `HFM_ADDR_CTL) begin
            simple_r <= regWdata[0];
         end
      end
   end

   // Return restore of virtualization
   // The flag stands one cycle; the value
   // holds until the next return
   always_ff @(posedge clk) begin
      if (!nrst) begin
         nv_r  <= 1'b0;
         nvv_r <= 1'b0;
      end else if (ce) begin
         nvv_r <= mretDo;
         if (mretDo) begin
            // Returning to machine mode never virtualizes
            nv_r <= (priorPriv == `HFM_PRIV_M) ? 1'b0 : pv_r;
         end
      end
   end

   // Register read port, data one cycle after the strobe
   // Zero outside that cycle, so a late
   // sample shows up as a wrong value
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rd_r <= '0;
      end else if (ce) begin
         rd_r <= '0;
         if (regRd && regAddr == `HFM_ADDR_SH) begin
            rd_r <= {24'h000000, pv_r, gva_r, mbe_r, sbe_r, 4'h0};
         end else if (regRd && regAddr == `HFM_ADDR_CTL) begin
            rd_r <= {31'h00000000, simple_r};
         end
      end
   end

   // Trap bits act only in hypervisor-supervisor; wait outside machine
   // Combinational so the pipeline can
   // trap the instruction in its own cycle
   assign srTrap      = srIssue && trapSr && hsMode;
   assign waitTrap    = waitIssue && trapWait && (priv != `HFM_PRIV_M);
   assign gTableBlock = gTableAcc && trapTm && hsMode;

   // Effective access mode under modified privilege
   // Only machine mode may borrow the
   // prior mode for its data accesses
   always_comb begin
      access = '0;
      if (modPriv && priv == `HFM_PRIV_M) begin
         access.priv = priorPriv;
         access.virt = (priorPriv == `HFM_PRIV_M) ? 1'b0 : pv_r;
      end else begin
         access.priv = priv;
         access.virt = virt;
      end
      access.bigEnd = (access.priv == `HFM_PRIV_M) ? mbe_r : sbe_r;
   end

   assign fenceExc   = exc_r;
   assign flush      = flush_r;
   assign regRdata   = rd_r;
   assign newVirt    = nv_r;
   assign newVirtVld = nvv_r;


   // Virtualized hypervisor fence raises a virtual fault next cycle
   a_virt_fence_fault: assert property (@(posedge clk) disable iff (!nrst)
      ce && fenceReq.valid && virt && fenceReq.kind inside {FK_GVV, FK_GPV}
      |=> fenceExc == EX_VIRTUAL && !flush.valid)
      else $error("virtualized fence not virtual fault");

   // User-mode hypervisor fence is illegal
   a_user_fence_ill: assert property (@(posedge clk) disable iff (!nrst)
      ce && fenceReq.valid && !virt && priv == `HFM_PRIV_U && fenceReq.kind != FK_CUR
      && fenceReq.kind != FK_NONE |=> fenceExc == EX_ILLEGAL)
      else $error("user fence not illegal");

   // Trap bit refuses the stage-two fence in host supervisor
   a_tm_gpv_ill: assert property (@(posedge clk) disable iff (!nrst)
      ce && fenceReq.valid && fenceReq.kind == FK_GPV && hsMode && trapTm
      |=> fenceExc == EX_ILLEGAL)
      else $error("trapping stage-two fence allowed");

   // Machine mode may always fence stage two
   a_machine_gpv_ok: assert property (@(posedge clk) disable iff (!nrst)
      ce && fenceReq.valid && fenceReq.kind == FK_GPV && priv == `HFM_PRIV_M && !virt
      |=> fenceExc == EX_NONE && flush.gStage)
      else $error("machine stage-two fence refused");

   // Trap bits never refuse the guest virtual fence
   a_gvv_no_trap: assert property (@(posedge clk) disable iff (!nrst)
      ce && fenceReq.valid && fenceReq.kind == FK_GVV && !virt && priv != `HFM_PRIV_U
      |=> fenceExc == EX_NONE && flush.guestTable)
      else $error("guest virtual fence trapped");

   // Stage-two address restored to byte units
   a_gpv_addr_shift: assert property (@(posedge clk) disable iff (!nrst)
      ce && fenceReq.valid && fenceReq.kind == FK_GPV && exc_nxt == EX_NONE
      |=> flush.addr == ($past(fenceReq.rs1Val) << `HFM_GPA_SHIFT))
      else $error("stage-two address not rescaled");

   // Trap captures mode and guest flag
   a_trap_saves_pv: assert property (@(posedge clk) disable iff (!nrst)
      ce && trapTaken |=> pv_r == $past(virt) && gva_r == $past(trapGva))
      else $error("trap did not save virtualization");

   // Return to machine mode never virtualizes
   a_machine_trap_return_restore: assert property (@(posedge clk) disable iff (!nrst)
      ce && mretDo && priorPriv == `HFM_PRIV_M |=> newVirtVld && !newVirt)
      else $error("return to machine virtualized");

   // Return below machine mode takes the prior bit
   a_machine_trap_return_prior_pv: assert property (@(posedge clk) disable iff (!nrst)
      ce && mretDo && priorPriv != `HFM_PRIV_M |=> newVirtVld && newVirt == $past(pv_r))
      else $error("return did not restore virtualization");

   // Wait never trapped in machine mode
   a_wait_machine: assert property (@(posedge clk) disable iff (!nrst)
      priv == `HFM_PRIV_M |-> !waitTrap)
      else $error("wait trapped in machine mode");

   // Guest supervisor sees no host-only traps
   a_guest_no_trap: assert property (@(posedge clk) disable iff (!nrst)
      virt |-> !srTrap && !gTableBlock)
      else $error("host trap bit acted while virtualized");

   // Host supervisor table access blocked by the trap bit
   a_tm_table_block: assert property (@(posedge clk) disable iff (!nrst)
      gTableAcc && trapTm && hsMode |-> gTableBlock)
      else $error("stage-two table access not blocked");

   // Current fence follows the active table
   a_cur_fence_table: assert property (@(posedge clk) disable iff (!nrst)
      ce && fenceReq.valid && fenceReq.kind == FK_CUR
      |=> flush.valid && flush.curTable && flush.guestTable == $past(virt))
      else $error("current fence on wrong table");

   // Guest virtual fence scoped to the identifier in force
   a_gvv_virtual_machine_identifier_scope: assert property (@(posedge clk) disable iff (!nrst)
      ce && fenceReq.valid && fenceReq.kind == FK_GVV && !virt && priv != `HFM_PRIV_U
      |=> flush.virtual_machine_identifier == $past(curVmid) && !flush.gStage)
      else $error("guest virtual fence identifier wrong");

   // Clock enable low holds the status bits
   a_ce_freeze_pv: assert property (@(posedge clk) disable iff (!nrst)
      !ce && nrst |=> $stable(pv_r) && $stable(gva_r))
      else $error("status bits moved while frozen");
endmodule

// >>> test/hfm_pipe_model.sv
// Purpose: pipeline-side model that launches fence requests
// Assumes: go is a one-cycle pulse, driven just after a rising edge
// Notes:  reserved operand bits are cleared the way software should
`timescale 1ns/1ps
`include "hfm_params.svh"
module hfm_pipe_model (
   input  wire logic                    clk,
   input  wire logic                    go,
   input  wire hfm_pkg::hfm_fence_kind_t kind,
   input  wire logic [`HFM_XLEN-1:0]    rs1,
   input  wire logic [`HFM_XLEN-1:0]    rs2,
   output hfm_pkg::hfm_fence_req_t      req
);
   import hfm_pkg::*;
   logic [`HFM_XLEN-1:0] opMask; // Keeps only bits up to the maximum width
   // Software clears operand bits above the maximum tag or identifier width
   assign opMask = (kind == FK_GPV) ? ((32'h1 << `HFM_VIRTUAL_MACHINE_IDENTIFIER_MAX) - 32'h1)
                                    : ((32'h1 << `HFM_TAG_MAX) - 32'h1);
   initial req = '0;
   // One request a pulse; idle operands toggle so stale values never look valid
   always @(posedge clk) begin
      req.valid  <= go;
      req.kind   <= go ? kind : FK_NONE;
      req.rs1Nz  <= go && (rs1 != '0);
      req.rs2Nz  <= go && (rs2 != '0);
      req.rs1Val <= go ? rs1 : ~req.rs1Val;
      req.rs2Val <= go ? (rs2 & opMask) : ~req.rs2Val;
   end
endmodule

// >>> test/tb_top.sv
// Purpose: self-checking bench for the fence and status control block
// Assumes: registered answers one cycle after the request is taken
// Notes:  combinational outputs are sampled at the falling edge
`timescale 1ns/1ps
`include "hfm_params.svh"
module tb_top;
   import hfm_pkg::*;
   logic            clk, nrst, ce, virt, modPriv, trapTm, trapSr, trapWait, go;
   logic            trapTaken, trapGva, mretDo, gTableAcc, srIssue, waitIssue, regWr, regRd;
   logic [1:0]      priv, priorPriv;
   logic [3:0]      curVmid;
   logic [11:0]     regAddr;
   logic [31:0]     regWdata, regRdata, rs1, rs2, a, b;
   logic            gTableBlock, srTrap, waitTrap, newVirt, newVirtVld;
   hfm_fence_kind_t kind;
   hfm_fence_req_t  fenceReq;
   hfm_exc_t        fenceExc, ex;
   hfm_flush_t      flush;
   hfm_access_t     access;
   int              nMismatch, cmpCount;
   hfm_pipe_model pipe (.clk(clk), .go(go), .kind(kind), .rs1(rs1), .rs2(rs2), .req(fenceReq));
   hfm_ctl uut (.clk(clk), .nrst(nrst), .ce(ce), .priv(priv), .virt(virt), .priorPriv(priorPriv),
      .modPriv(modPriv), .trapTm(trapTm), .trapSr(trapSr), .trapWait(trapWait), .curVmid(curVmid),
      .bigEndS(1'b0), .fenceReq(fenceReq), .trapTaken(trapTaken), .trapGva(trapGva), .mretDo(mretDo),
      .gTableAcc(gTableAcc), .srIssue(srIssue), .waitIssue(waitIssue), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .fenceExc(fenceExc),
      .flush(flush), .gTableBlock(gTableBlock), .srTrap(srTrap), .waitTrap(waitTrap),
      .newVirt(newVirt), .newVirtVld(newVirtVld), .access(access));
   // Free-running hart clock, 25 MHz
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chkVal(input logic [31:0] act, input logic [31:0] exp);
      cmpCount++;
      if (act !== exp) begin
         nMismatch++;
         $display("CHECK FAILED t=%0t act=%h exp=%h", $time, act, exp);
      end
   endtask
   task automatic chkExc(input hfm_exc_t act, input hfm_exc_t exp);
      cmpCount++;
      if (act !== exp) begin
         nMismatch++;
         $display("CHECK FAILED t=%0t act=%h exp=%h", $time, act, exp);
      end
   endtask
   task automatic closeOut();
      $display("Compares %0d mismatches %0d", cmpCount, nMismatch);
      if (nMismatch == 0 && cmpCount > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Register read; data stand only in the cycle after the strobe
   task automatic regRead(input logic [11:0] ad, input logic [31:0] m, input logic [31:0] exp);
      @(posedge clk);
      regAddr <= ad;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      chkVal(regRdata & m, exp);
   endtask
   task automatic regWrite(input logic [11:0] ad, input logic [31:0] d);
      @(posedge clk);
      regAddr <= ad;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   // Expected fence outcome from mode, virtualization and the trap bit
   function automatic hfm_exc_t expExc(hfm_fence_kind_t k, logic [1:0] p, logic v, logic tm);
      if (k == FK_CUR) return EX_NONE;
      if (v) return EX_VIRTUAL;
      if (p == `HFM_PRIV_U) return EX_ILLEGAL;
      if (k == FK_GPV && p == `HFM_PRIV_S && tm) return EX_ILLEGAL;
      return EX_NONE;
   endfunction
   // Launch through the model, then look at the one-cycle answer
   task automatic doFence(input hfm_fence_kind_t k, input hfm_exc_t exp);
      @(posedge clk);
      kind <= k;
      rs1 <= a;
      rs2 <= b;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      chkExc(fenceExc, exp);
      chkVal(flush.valid, exp == EX_NONE);
   endtask
   // Pulse on a trap or return strobe with its qualifiers
   task automatic pulse(input logic t, input logic r, input logic v, input logic g, input logic [1:0] pp);
      @(posedge clk);
      virt <= v;
      trapGva <= g;
      priorPriv <= pp;
      trapTaken <= t;
      mretDo <= r;
      @(posedge clk);
      trapTaken <= 1'b0;
      mretDo <= 1'b0;
      @(negedge clk);
   endtask
   // Mode-dependent trap strobes, all qualifiers raised
   task automatic modeChk(input logic [1:0] p, input logic v);
      @(posedge clk);
      {priv, virt} <= {p, v};
      {trapTm, trapSr, trapWait, gTableAcc, srIssue, waitIssue} <= 6'h3F;
      @(negedge clk);
      chkVal(gTableBlock, p == `HFM_PRIV_S && !v);
      chkVal(srTrap, p == `HFM_PRIV_S && !v);
      chkVal(waitTrap, p != `HFM_PRIV_M);
      @(posedge clk);
      {gTableAcc, srIssue, waitIssue} <= 3'h0;
   endtask
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      nMismatch++;
      closeOut();
   end
   // Main sequence
   initial begin
      {nrst, virt, modPriv, trapTm, trapSr, trapWait, go, trapTaken, trapGva} = 9'h0;
      {mretDo, gTableAcc, srIssue, waitIssue, regWr, regRd} = 6'h0;
      {priv, priorPriv, curVmid, regAddr} = 20'h0;
      {regWdata, rs1, rs2, a, b} = 160'h0;
      kind = FK_NONE;
      ce = 1'b1;
      nMismatch = 0;
      cmpCount = 0;
      void'($urandom(32'hE266));
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      regRead(12'h000, 32'h000000C0, 32'h0);
      regRead(12'h0A5, 32'hFFFFFFFF, 32'h0);
      // Legality table over mode, virtualization, trap bit and fence kind
      for (int i = 0; i < 32; i++) begin
         if (i[4:3] == 2'h2 || (i[4:3] == `HFM_PRIV_M && i[2])) continue;
         @(posedge clk);
         {priv, virt, trapTm} <= {i[4:3], i[2], i[1]};
         curVmid <= $urandom;
         a = $urandom;
         b = $urandom | 32'h1;
         ex = expExc(i[0] ? FK_GPV : FK_GVV, i[4:3], i[2], i[1]);
         doFence(i[0] ? FK_GPV : FK_GVV, ex);
         if (ex == EX_NONE && i[0]) begin
            chkVal(flush.addr, a << `HFM_GPA_SHIFT);
            chkVal(flush.virtual_machine_identifier, b[3:0]);
            chkVal(flush.gStage & flush.orderStores, 32'h1);
         end else if (ex == EX_NONE) begin
            chkVal(flush.tag, b[5:0]);
            chkVal(flush.virtual_machine_identifier, curVmid);
            chkVal(flush.orderStores, 32'h1);
         end
      end
      // Current fence picks the table by virtualization
      for (int v = 0; v < 2; v++) begin
         @(posedge clk);
         {priv, virt} <= {`HFM_PRIV_S, v[0]};
         doFence(FK_CUR, EX_NONE);
         chkVal({flush.curTable, flush.guestTable}, {31'h00000001, v[0]});
      end
      // Simplified global fence selected through the control register
      regWrite(12'h001, 32'h1);
      @(posedge clk);
      {priv, virt} <= {`HFM_PRIV_M, 1'b0};
      doFence(FK_GPV, EX_NONE);
      chkVal(flush.global, 32'h1);
      regWrite(12'h001, 32'h0);
      // Zero operands once simple fences are off: stage-two flush of all machines
      a = 32'h0;
      b = 32'h0;
      doFence(FK_GPV, EX_NONE);
      chkVal({flush.useAddr, flush.useTag, flush.global}, 32'h1);
      // Trap saves virtualization and guest-address flag
      pulse(1'b1, 1'b0, 1'b1, 1'b1, 2'h0);
      regRead(12'h000, 32'h000000C0, 32'h000000C0);
      pulse(1'b1, 1'b0, 1'b0, 1'b0, 2'h0);
      regRead(12'h000, 32'h000000C0, 32'h0);
      pulse(1'b1, 1'b0, 1'b1, 1'b0, 2'h0);
      // Frozen by clock enable: this trap must leave no mark
      ce <= 1'b0;
      pulse(1'b1, 1'b0, 1'b0, 1'b1, 2'h0);
      ce <= 1'b1;
      regRead(12'h000, 32'h000000C0, 32'h00000080);
      pulse(1'b0, 1'b1, 1'b0, 1'b0, `HFM_PRIV_M);
      chkVal({newVirtVld, newVirt}, 32'h2);
      pulse(1'b0, 1'b1, 1'b0, 1'b0, `HFM_PRIV_S);
      chkVal({newVirtVld, newVirt}, 32'h3);
      modeChk(`HFM_PRIV_M, 1'b0);
      modeChk(`HFM_PRIV_S, 1'b0);
      modeChk(`HFM_PRIV_S, 1'b1);
      modeChk(`HFM_PRIV_U, 1'b1);
      // Modified privilege borrows prior virtualization and privilege
      @(posedge clk);
      {priv, virt, modPriv, priorPriv} <= {`HFM_PRIV_M, 1'b0, 1'b1, `HFM_PRIV_S};
      @(negedge clk);
      chkVal({access.virt, access.priv}, 32'h5);
      @(posedge clk);
      modPriv <= 1'b0;
      @(negedge clk);
      chkVal({access.virt, access.priv}, 32'h3);
      // Machine byte order follows its own status bit
      regWrite(12'h000, 32'h00000020);
      @(negedge clk);
      chkVal(access.bigEnd, 32'h1);
      regWrite(12'h000, 32'h00000010);
      @(negedge clk);
      chkVal(access.bigEnd, 32'h0);
      closeOut();
   end
endmodule
